/* hdl/spp_pkg.sv */
// constants and carrier types of the stream packet pacer
`default_nettype none
package spp_pkg;
    // register offsets
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_CHAN      = 8'h04;
    localparam logic [7:0] REG_PKTSIZE   = 8'h08;
    localparam logic [7:0] REG_GAP       = 8'h0C;
    localparam logic [7:0] REG_FDELAY    = 8'h10;
    localparam logic [7:0] REG_IMGBYTES  = 8'h14;
    localparam logic [7:0] REG_CHUNK     = 8'h18;
    localparam logic [7:0] REG_PAYLOAD   = 8'h1C;
    localparam logic [7:0] REG_TICKF     = 8'h20;
    localparam logic [7:0] REG_BWASSIGN  = 8'h24;
    localparam logic [7:0] REG_BWRESV    = 8'h28;
    localparam logic [7:0] REG_RESVBPS   = 8'h2C;
    localparam logic [7:0] REG_KALIMIT   = 8'h30;
    localparam logic [7:0] REG_KAREFRESH = 8'h34;
    localparam logic [7:0] REG_STATUS    = 8'h38;
    localparam logic [7:0] REG_INTSTS    = 8'h3C;
    localparam logic [7:0] REG_INTMASK   = 8'h40;
    // field positions
    localparam int CTRL_EN        = 0;
    localparam int CTRL_CHUNK     = 1;
    localparam int STAT_CONN      = 0;
    localparam int STAT_BUSY      = 1;
    localparam int INT_FRAME_DONE = 0;
    localparam int INT_KA_TIMEOUT = 1;
    localparam int INT_FRAME_DROP = 2;
    // reset values and reserve percentage limit
    localparam logic [15:0] PKTSIZE_RST = 16'h05DC;
    localparam logic [31:0] KALIMIT_RST = 32'h0000_0BB8;
    localparam logic [6:0]  RESV_RST    = 7'h0A;
    localparam logic [6:0]  RESV_MAX    = 7'h64;
    // timing
    localparam int CLK_NS    = 10;
    localparam int TICK_NS   = 8;
    localparam int MS_NS     = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_NS;
    localparam logic [31:0] TICK_FREQ = 32'(1000000000 / TICK_NS);
    // framing
    localparam logic [31:0] HDR_BYTES     = 32'h0000_0024;
    localparam logic [31:0] LEADER_BYTES  = 32'h0000_0012;
    localparam logic [31:0] TRAILER_BYTES = HDR_BYTES - LEADER_BYTES;

    typedef enum logic [1:0] {
        SPP_LEADER  = 2'b00,
        SPP_PAYLOAD = 2'b01,
        SPP_TRAILER = 2'b10
    } spp_kind_t;

    typedef struct packed {
        spp_kind_t   kind;
        logic [31:0] len;
    } spp_tx_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } spp_bus_t;

    typedef struct packed {
        logic [31:0] gap;
        logic [31:0] dataPer;
    } spp_cfg_t;
endpackage
`default_nettype wire

/* hdl/spp_divider.sv */
// sequential restoring divider, saturating 32-bit quotient
`default_nettype none
module spp_divider (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // request
    input  wire logic        start,
    input  wire logic [63:0] num,
    input  wire logic [31:0] den,
    // answer
    output logic             done,
    output logic [31:0]      quot
);
    typedef struct packed {
        logic        busy;
        logic [5:0]  cnt;
        logic [32:0] rem;
        logic [63:0] q;
        logic [31:0] den;
        logic        done;
        logic [31:0] quot;
    } spp_div_t;

    spp_div_t s_q;
    spp_div_t s_d;
    logic [32:0] r;
    logic [63:0] qn;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        r = {s_q.rem[31:0], s_q.q[63]};
        qn = {s_q.q[62:0], 1'b0};
        if (r >= {1'b0, s_q.den}) begin
            r = r - {1'b0, s_q.den};
            qn[0] = 1'b1;
        end
        if (s_q.busy) begin
            s_d.rem = r;
            s_d.q = qn;
            s_d.cnt = s_q.cnt + 6'h01;
            if (s_q.cnt == 6'h3F) begin
                // zero divisor ends as all ones, same as saturation
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.quot = (|qn[63:32]) ? 32'hFFFF_FFFF : qn[31:0];
            end
        end else if (start) begin
            s_d.busy = 1'b1;
            s_d.cnt = 6'h00;
            s_d.rem = 33'h0_0000_0000;
            s_d.q = num;
            s_d.den = den;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign quot = s_q.quot;
endmodule
`default_nettype wire

/* hdl/spp_stream_packet_pacer.sv */
// stream packet pacer: block framing, tick pacing, keepalive, registers
//
// Operation
// R1: keepalive limit in ms passes unrefreshed: drop link, allow reconnect
// R2: host refreshes the keepalive before its limit runs out
// R3: host fails a register read with no reply within read_reply_limit
// R4: host fails a register write with no ack within write_ack_limit
// R5: one stream channel only, number 0; selector accepts 0 only
// R6: each frame is leader, one or more payload packets, trailer
// R7: payload packets use packet size; last one may be shorter
// R8: leader plus trailer is 36 bytes; data per packet is size minus 36
// R9: read-only payload size is image bytes plus chunk bytes if enabled
// R10: programmable idle gap in ticks between consecutive packets
// R11: one tick is 8 ns; tick frequency readable in ticks per second
// R12: frame start held off by programmable tick count, normally zero
// R13: read-only assigned bandwidth from packet size and gap
// R14: one byte costs one tick on the link
// R15: programmable percentage of bandwidth reserved for resends
// R16: host packet timeout must exceed the inter-packet gap
// R17: host waits its packet timeout before asking for resends
// R18: gap and delay counted in 125 MHz ticks, fully expired before send
// R19: new size, gap, delay take effect only at block boundaries
////////////////////////////////////////////////////////////////////////////
`default_nettype none
module spp_stream_packet_pacer #(
    parameter int unsigned CYC_PER_MS = spp_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // register port
    input  wire spp_pkg::spp_bus_t busReq,
    output logic [31:0]            rdData,
    // acquisition and link
    input  wire logic              frameReq,
    input  wire logic              hostConnect,
    input  wire logic              keepAliveRefresh,
    output logic                   txValid,
    output spp_pkg::spp_tx_t       tx,
    output logic                   linkConnected,
    output logic                   linkRelease,
    // interrupt
    output logic                   irq
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DELAY = 3'b001,
        ST_SEND  = 3'b010,
        ST_XMIT  = 3'b011,
        ST_GAP   = 3'b100
    } spp_state_e_t;

    typedef struct packed {
        logic              en;
        logic              chunkEn;
        logic [15:0]       pktSize;
        logic [31:0]       gap;
        logic [31:0]       fdelay;
        logic [31:0]       imgBytes;
        logic [31:0]       chunkBytes;
        logic [31:0]       kaLimit;
        logic [6:0]        resvPct;
        logic [2:0]        intSts;
        logic [2:0]        intMask;
        logic              connected;
        logic              pending;
        logic [2:0]        tickPh;
        logic [31:0]       tickCnt;
        spp_state_e_t      st;
        spp_pkg::spp_kind_t kind;
        spp_pkg::spp_cfg_t frame;
        logic [31:0]       remain;
        logic [31:0]       waitRem;
        logic [31:0]       msCyc;
        logic [31:0]       msCnt;
        logic [1:0]        calcPh;
        logic              calcRun;
        logic              divStart;
        logic [31:0]       nPay;
        logic [31:0]       bwAssign;
        logic [31:0]       resvBps;
        logic [31:0]       rdData;
        logic              irq;
        logic              txValid;
        spp_pkg::spp_tx_t  tx;
        logic              linkRelease;
    } spp_regs_t;

    spp_regs_t   s_q;
    spp_regs_t   s_d;
    logic        divDone;
    logic [31:0] divQuot;
    logic [63:0] divNum;
    logic [31:0] divDen;
    logic [31:0] payloadNow;
    logic [31:0] dataPer;
    logic [31:0] pktX;
    logic [31:0] total;
    logic [4:0]  tickSum;
    logic [1:0]  ticksNow;
    logic        waitDone;
    logic        refresh;
    logic [2:0]  events;
    logic [2:0]  w1c;

    function automatic logic isWr(input spp_pkg::spp_bus_t b,
                                  input logic [7:0] a);
        isWr = b.wr && (b.addr == a);
    endfunction

    function automatic logic [31:0] minU(input logic [31:0] a,
                                         input logic [31:0] b);
        minU = (a < b) ? a : b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // derived values shared by framing and bandwidth report
    always_comb begin
        // R9: payload size read-only
        payloadNow = s_q.imgBytes + (s_q.chunkEn ? s_q.chunkBytes : 32'h0);
        // R8: data per packet
        dataPer = ({16'h0, s_q.pktSize} > spp_pkg::HDR_BYTES)
                ? {16'h0, s_q.pktSize} - spp_pkg::HDR_BYTES : 32'h1;
        pktX = s_q.nPay + 32'h2;
        total = 32'(pktX * {16'h0, s_q.pktSize});
        // R13: bandwidth formula, scaled by ticks per second
        unique case (s_q.calcPh)
            2'h0: begin
                divNum = {32'h0, payloadNow + dataPer - 32'h1};
                divDen = dataPer;
            end
            2'h1: begin
                divNum = 64'(total) * 64'(spp_pkg::TICK_FREQ);
                divDen = total + 32'((pktX - 32'h1) * s_q.gap);
            end
            default: begin
                // R15: reserve share of assigned bandwidth
                divNum = 64'(s_q.bwAssign) * 64'(s_q.resvPct);
                divDen = 32'(spp_pkg::RESV_MAX);
            end
        endcase
    end

    spp_divider u_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (s_q.divStart),
        .num     (divNum),
        .den     (divDen),
        .done    (divDone),
        .quot    (divQuot)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.txValid = 1'b0;
        s_d.linkRelease = 1'b0;
        s_d.divStart = 1'b0;
        events = 3'h0;
        w1c = 3'h0;
        // R11: 8 ns ticks from a 10 ns clock, 1 or 2 per cycle
        tickSum = 5'(s_q.tickPh) + 5'(spp_pkg::CLK_NS);
        ticksNow = (tickSum >= 5'h10) ? 2'h2 : 2'h1;
        s_d.tickPh = 3'(tickSum - {ticksNow, 3'h0});
        s_d.tickCnt = s_q.tickCnt + 32'(ticksNow);
        // R18: wait ends only once the full count has passed
        waitDone = s_q.waitRem <= 32'(ticksNow);

        // register writes
        if (busReq.wr) begin
            case (busReq.addr)
                spp_pkg::REG_CTRL: begin
                    s_d.en = busReq.wdata[spp_pkg::CTRL_EN];
                    s_d.chunkEn = busReq.wdata[spp_pkg::CTRL_CHUNK];
                end
                spp_pkg::REG_PKTSIZE:  s_d.pktSize = busReq.wdata[15:0];
                spp_pkg::REG_GAP:      s_d.gap = busReq.wdata;
                spp_pkg::REG_FDELAY:   s_d.fdelay = busReq.wdata;
                spp_pkg::REG_IMGBYTES: s_d.imgBytes = busReq.wdata;
                spp_pkg::REG_CHUNK:    s_d.chunkBytes = busReq.wdata;
                spp_pkg::REG_KALIMIT:  s_d.kaLimit = busReq.wdata;
                spp_pkg::REG_INTMASK:  s_d.intMask = busReq.wdata[2:0];
                spp_pkg::REG_INTSTS:   w1c = busReq.wdata[2:0];
                spp_pkg::REG_BWRESV: begin
                    s_d.resvPct = (busReq.wdata > 32'(spp_pkg::RESV_MAX))
                                ? spp_pkg::RESV_MAX : busReq.wdata[6:0];
                end
                // R5: channel 0 only, so the selector holds nothing
                default: ;
            endcase
        end

        // register reads, answered in the next cycle
        s_d.rdData = 32'h0;
        if (busReq.rd) begin
            case (busReq.addr)
                spp_pkg::REG_CTRL: begin
                    s_d.rdData = {30'h0, s_q.chunkEn, s_q.en};
                end
                spp_pkg::REG_PKTSIZE:  s_d.rdData = {16'h0, s_q.pktSize};
                spp_pkg::REG_GAP:      s_d.rdData = s_q.gap;
                spp_pkg::REG_FDELAY:   s_d.rdData = s_q.fdelay;
                spp_pkg::REG_IMGBYTES: s_d.rdData = s_q.imgBytes;
                spp_pkg::REG_CHUNK:    s_d.rdData = s_q.chunkBytes;
                spp_pkg::REG_PAYLOAD:  s_d.rdData = payloadNow;
                spp_pkg::REG_TICKF:    s_d.rdData = spp_pkg::TICK_FREQ;
                spp_pkg::REG_BWASSIGN: s_d.rdData = s_q.bwAssign;
                spp_pkg::REG_BWRESV:   s_d.rdData = {25'h0, s_q.resvPct};
                spp_pkg::REG_RESVBPS:  s_d.rdData = s_q.resvBps;
                spp_pkg::REG_KALIMIT:  s_d.rdData = s_q.kaLimit;
                spp_pkg::REG_STATUS: begin
                    s_d.rdData = {30'h0, s_q.st != ST_IDLE, s_q.connected};
                end
                spp_pkg::REG_INTSTS:   s_d.rdData = {29'h0, s_q.intSts};
                spp_pkg::REG_INTMASK:  s_d.rdData = {29'h0, s_q.intMask};
                default:               s_d.rdData = 32'h0;
            endcase
        end

        // R2: host refresh, also by register write or a new connect
        refresh = keepAliveRefresh || hostConnect
               || isWr(busReq, spp_pkg::REG_KAREFRESH);
        if (hostConnect) begin
            s_d.connected = 1'b1;
        end
        if (refresh || !s_q.connected) begin
            s_d.msCyc = 32'h0;
            s_d.msCnt = 32'h0;
        end else if (s_q.msCyc == 32'(CYC_PER_MS - 1)) begin
            s_d.msCyc = 32'h0;
            s_d.msCnt = s_q.msCnt + 32'h1;
        end else begin
            s_d.msCyc = s_q.msCyc + 32'h1;
        end
        // R1: keepalive expiry drops the link
        if (s_q.connected && !refresh && (s_q.msCnt >= s_q.kaLimit)) begin
            s_d.connected = 1'b0;
            s_d.linkRelease = 1'b1;
            events[spp_pkg::INT_KA_TIMEOUT] = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////
        // block sequencer
        unique case (s_q.st)
            ST_IDLE: begin
                if (s_q.pending && s_q.connected && s_q.en) begin
                    s_d.pending = 1'b0;
                    // R19: framing settings caught once per block
                    s_d.frame.gap = s_q.gap;
                    s_d.frame.dataPer = dataPer;
                    s_d.remain = payloadNow;
                    // R12: start held off by the frame delay
                    s_d.waitRem = s_q.fdelay;
                    s_d.kind = spp_pkg::SPP_LEADER;
                    s_d.st = ST_DELAY;
                end
            end
            ST_DELAY, ST_GAP: begin
                // R10, R12: idle gap or frame delay before the next packet
                if (waitDone) begin
                    s_d.st = ST_SEND;
                end else begin
                    s_d.waitRem = s_q.waitRem - 32'(ticksNow);
                end
            end
            ST_SEND: begin
                s_d.txValid = 1'b1;
                s_d.tx.kind = s_q.kind;
                s_d.st = ST_XMIT;
                // R14: wire time in ticks equals bytes
                unique case (s_q.kind)
                    spp_pkg::SPP_LEADER: begin
                        s_d.tx.len = spp_pkg::LEADER_BYTES;
                        s_d.waitRem = spp_pkg::LEADER_BYTES;
                    end
                    spp_pkg::SPP_PAYLOAD: begin
                        // R7: full size, shorter last packet
                        s_d.tx.len = minU(s_q.remain, s_q.frame.dataPer);
                        s_d.remain = s_q.remain - s_d.tx.len;
                        s_d.waitRem = s_d.tx.len + spp_pkg::HDR_BYTES;
                    end
                    default: begin
                        s_d.tx.len = spp_pkg::TRAILER_BYTES;
                        s_d.waitRem = spp_pkg::TRAILER_BYTES;
                    end
                endcase
            end
            ST_XMIT: begin
                if (!waitDone) begin
                    s_d.waitRem = s_q.waitRem - 32'(ticksNow);
                end else if (s_q.kind == spp_pkg::SPP_TRAILER) begin
                    s_d.st = ST_IDLE;
                    events[spp_pkg::INT_FRAME_DONE] = 1'b1;
                end else begin
                    // R6: leader always followed by a payload packet
                    s_d.kind = (s_q.kind == spp_pkg::SPP_LEADER
                                || s_q.remain != 32'h0)
                             ? spp_pkg::SPP_PAYLOAD : spp_pkg::SPP_TRAILER;
                    s_d.waitRem = s_q.frame.gap;
                    s_d.st = ST_GAP;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
        // a lost link ends the block in progress
        if (s_d.linkRelease) begin
            s_d.st = ST_IDLE;
            s_d.txValid = 1'b0;
            s_d.pending = 1'b0;
        end

        // request taken after consumption so a new one in the same cycle is not lost
        if (frameReq) begin
            if (s_q.connected) begin
                s_d.pending = 1'b1;
            end else begin
                events[spp_pkg::INT_FRAME_DROP] = 1'b1;
            end
        end

        // bandwidth report loops through three divisions
        if (!s_q.calcRun) begin
            s_d.calcRun = 1'b1;
            s_d.divStart = 1'b1;
        end else if (divDone) begin
            s_d.divStart = 1'b1;
            unique case (s_q.calcPh)
                2'h0: begin
                    s_d.nPay = divQuot;
                    s_d.calcPh = 2'h1;
                end
                2'h1: begin
                    s_d.bwAssign = divQuot;
                    s_d.calcPh = 2'h2;
                end
                default: begin
                    s_d.resvBps = divQuot;
                    s_d.calcPh = 2'h0;
                end
            endcase
        end

        // set wins over a clear in the same cycle
        s_d.intSts = (s_q.intSts & ~w1c) | events;
        s_d.irq = |(s_d.intSts & s_d.intMask);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.pktSize <= spp_pkg::PKTSIZE_RST;
            s_q.kaLimit <= spp_pkg::KALIMIT_RST;
            s_q.resvPct <= spp_pkg::RESV_RST;
            s_q.waitRem <= 32'h0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdData        = s_q.rdData;
    assign irq           = s_q.irq;
    assign txValid       = s_q.txValid;
    assign tx            = s_q.tx;
    assign linkConnected = s_q.connected;
    assign linkRelease   = s_q.linkRelease;

    ////////////////////////////////////////////////////////////////////////
    // checks
    spp_pkg::spp_kind_t lastKind;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lastKind <= spp_pkg::SPP_TRAILER;
        end else if (txValid) begin
            lastKind <= tx.kind;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_KA_DROP: assert property ( // R1
        linkRelease |-> !linkConnected && $past(linkConnected)
            && s_q.st == ST_IDLE)
        else $error("keepalive drop did not release link");
    AST_CHAN_ZERO: assert property ( // R5
        busReq.rd && busReq.addr == spp_pkg::REG_CHAN |=> rdData == 32'h0)
        else $error("channel selector not zero");
    AST_LEADER_OPENS: assert property ( // R6
        txValid && tx.kind == spp_pkg::SPP_LEADER
            |-> lastKind == spp_pkg::SPP_TRAILER)
        else $error("leader inside a block");
    AST_TRAILER_CLOSES: assert property ( // R6
        txValid && tx.kind == spp_pkg::SPP_TRAILER
            |-> lastKind == spp_pkg::SPP_PAYLOAD)
        else $error("trailer without payload");
    AST_PAYLOAD_LEN: assert property ( // R7
        txValid && tx.kind == spp_pkg::SPP_PAYLOAD
            |-> tx.len <= s_q.frame.dataPer)
        else $error("payload packet too long");
    AST_PAYLOAD_READ: assert property ( // R9
        busReq.rd && busReq.addr == spp_pkg::REG_PAYLOAD
            |=> rdData == $past(payloadNow))
        else $error("payload size readback wrong");
    AST_TICK_FREQ: assert property ( // R11
        busReq.rd && busReq.addr == spp_pkg::REG_TICKF
            |=> rdData == spp_pkg::TICK_FREQ)
        else $error("tick frequency wrong");
    AST_GAP_EXPIRE: assert property ( // R18
        s_q.st == ST_GAP && !waitDone |=> s_q.st != ST_SEND)
        else $error("packet sent before gap expired");
    AST_WIRE_TIME: assert property ( // R14
        txValid |-> s_q.st == ST_XMIT && s_q.waitRem >= tx.len)
        else $error("wire time shorter than packet");
    AST_DELAY_LOAD: assert property ( // R12
        s_q.st == ST_DELAY && $past(s_q.st) == ST_IDLE
            |-> s_q.waitRem == $past(s_q.fdelay))
        else $error("frame delay not loaded");
    AST_CFG_HOLD: assert property ( // R19
        s_q.st != ST_IDLE && $past(s_q.st) != ST_IDLE
            |-> $stable(s_q.frame))
        else $error("framing changed inside a block");

    COV_LEADER: cover property (txValid && tx.kind == spp_pkg::SPP_LEADER);
    COV_TRAILER: cover property (txValid && tx.kind == spp_pkg::SPP_TRAILER);
    COV_KA_DROP: cover property (linkRelease);
    COV_IRQ: cover property ($rose(irq));
endmodule
`default_nettype wire

/* verif/spp_host_model.sv */
// host side model: opens the link and keeps it refreshed
`default_nettype none
module spp_host_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // control from bench
    input  wire logic connReq,
    input  wire logic kaOn,
    // link toward the device
    output logic      hostConnect,
    output logic      keepAliveRefresh
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] tmr;
    assign hostConnect = connReq;
    ////////////////////////////////////////////////////////////////////////
    // periodic refresh
    // refresh every 16 cycles, well inside any limit the bench programs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tmr              <= 4'h0;
            keepAliveRefresh <= 1'b0;
        end else begin
            tmr              <= tmr + 4'h1;
            keepAliveRefresh <= kaOn && tmr == 4'hF;
        end
    end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench of the stream packet pacer
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              frameReq = 1'b0;
    logic              connReq = 1'b0;
    logic              kaOn = 1'b1;
    spp_pkg::spp_bus_t busReq = '0;
    spp_pkg::spp_tx_t  tx;
    logic [31:0]       rdData, q;
    logic              txValid, linkConnected, linkRelease, irq;
    logic              hostConnect, keepAliveRefresh;
    int                n_mismatch = 0, n_tests = 0, seed = 17, cyc = 0;
    initial forever #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    spp_stream_packet_pacer #(.CYC_PER_MS(10)) dut (.clk(clk),
        .sys_rst(sys_rst), .busReq(busReq), .rdData(rdData),
        .frameReq(frameReq), .hostConnect(hostConnect),
        .keepAliveRefresh(keepAliveRefresh), .txValid(txValid), .tx(tx),
        .linkConnected(linkConnected), .linkRelease(linkRelease), .irq(irq));
    spp_host_model host (.clk(clk), .sys_rst(sys_rst), .connReq(connReq),
        .kaOn(kaOn), .hostConnect(hostConnect),
        .keepAliveRefresh(keepAliveRefresh));
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk) busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) busReq <= '0;
    endtask
    // reply due next cycle, never waited on
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk) busReq <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk) busReq <= '0;
        #1 d = rdData;
    endtask
    // bound far above any gap; expiry closes the run
    task automatic waitSig(ref logic s, input string nm);
        int k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (s !== 1'b1 && k < 3000);
        if (k == 3000) begin
            chk(nm, 32'h0, 32'h1);
            final_report();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // expected bandwidth
    function automatic int bw(int p, int s, int g);
        longint x;
        x = (p + s - 37) / (s - 36) + 2;
        return int'(x * s * 125000000 / (x * s + (x - 1) * g));
    endfunction
    task automatic frame(int img, int dp, int gp, int fd, bit ch);
        int rem, t0, w, n, el;
        spp_pkg::spp_kind_t ek;
        rem = img + (ch ? 8 : 0);
        wr(spp_pkg::REG_CTRL, {30'h0, ch, 1'b1});
        rd(spp_pkg::REG_PAYLOAD, q);
        chk("payload", q, rem);
        @(posedge clk) frameReq <= 1'b1;
        @(posedge clk) frameReq <= 1'b0;
        t0 = cyc;
        n = 0;
        do begin
            waitSig(txValid, "tx");
            w = (n == 0) ? fd : w + gp;
            chk("spacing", (cyc - t0) * 10 >= w * 8, 1);
            t0 = cyc;
            if (n == 0) begin
                ek = spp_pkg::SPP_LEADER;
                el = 18;
            end else if (rem == 0 && n > 1) begin
                ek = spp_pkg::SPP_TRAILER;
                el = 18;
            end else begin
                ek = spp_pkg::SPP_PAYLOAD;
                el = rem < dp ? rem : dp;
                rem -= el;
            end
            chk("kind", tx.kind, ek);
            chk("len", tx.len, el);
            w = (ek == spp_pkg::SPP_PAYLOAD) ? el + 36 : el;
            // size change mid-block must not reshape this block
            if (n == 0) wr(spp_pkg::REG_PKTSIZE, dp + 136);
            n++;
        end while (ek != spp_pkg::SPP_TRAILER && n < 300);
        waitSig(irq, "irq");
        wr(spp_pkg::REG_INTSTS, 32'h1);
        repeat (3) @(posedge clk);
        #1 chk("irqclr", irq, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int dp, img, gp;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(spp_pkg::REG_PKTSIZE, q);
        chk("pktsize", q, 32'h000005DC);
        rd(spp_pkg::REG_TICKF, q);
        chk("tickf", q, 32'(1000000000 / 8));
        wr(spp_pkg::REG_CHAN, 32'h1);
        rd(spp_pkg::REG_CHAN, q);
        chk("chan", q, 0);
        rd(8'hFC, q);
        chk("unmapped", q, 0);
        wr(spp_pkg::REG_BWRESV, 32'hC8);
        rd(spp_pkg::REG_BWRESV, q);
        chk("resv", q, 32'h64);
        wr(spp_pkg::REG_INTMASK, 32'h1);
        @(posedge clk) connReq <= 1'b1;
        @(posedge clk) connReq <= 1'b0;
        // first pass: image an exact multiple of the data per packet
        for (int i = 0; i < 4; i++) begin
            dp = 20 + ($random(seed) & 63);
            img = (i == 0) ? 3 * dp : 40 + ($random(seed) & 255);
            gp = $random(seed) & 31;
            wr(spp_pkg::REG_PKTSIZE, dp + 36);
            wr(spp_pkg::REG_GAP, gp);
            wr(spp_pkg::REG_FDELAY, i == 3 ? 100 : 0);
            wr(spp_pkg::REG_IMGBYTES, img);
            wr(spp_pkg::REG_CHUNK, 32'h8);
            frame(img, dp, gp, i == 3 ? 100 : 0, i[0]);
            repeat (450) @(posedge clk);
            rd(spp_pkg::REG_BWASSIGN, q);
            chk("bw", q, bw(img + (i[0] ? 8 : 0), dp + 136, gp));
        end
        kaOn <= 1'b0;
        wr(spp_pkg::REG_KALIMIT, 32'h3);
        waitSig(linkRelease, "release");
        chk("conn", linkConnected, 0);
        @(posedge clk) frameReq <= 1'b1;
        @(posedge clk) frameReq <= 1'b0;
        rd(spp_pkg::REG_INTSTS, q);
        chk("sts", q[2:1], 2'h3);
        chk("masked", irq, 0);
        @(posedge clk) connReq <= 1'b1;
        @(posedge clk) connReq <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("reconn", linkConnected, 1);
        final_report();
    end
endmodule
`default_nettype wire
